/* hw/laser_interlock_status_outputs.sv */
// Safety interlock, main power sequencer and hardwired status outputs
// of a fiber laser.
// Assumes one 125 MHz clock, synchronous active-low reset, connector
// pins asynchronous to clk and control status on clk.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [R1] Abnormal end set on abort, cleared by reset
// [R2] Sync output only in programming mode
// [R3] Warning output follows warning condition
// [R4] Gate channel code, four bits, LSB first
// [R5] Cooler warning output during warning range
// [R6] Cooler alarm output and emission inhibit
// [R7] Pulsed mode output when supported and active
// [R8] Unit address on four-bit output
// [R9] Power start only with both channels closed
// [R10] One channel opened: both must reopen first
// [R11] Open loop removes optical module power
// [R12] Start press with safe conditions powers on
// [R13] Loop open or error switches power off
// [R14] Errors latch, reset loop held open
// [R15] Channel or start short blocks loop reset
// [R16] Alarm reset edge clears alarm, 1 ms
// [R17] Safety pins synchronised and debounced
module laser_interlock_status_outputs
    import ilk_pkg::*;
#(
    parameter int              DEB_CYC       = DEBOUNCE_CYC,
    parameter int              ARST_CYC      = ALARM_RST_CYC,
    parameter int              CNT_W         = 17,
    parameter bit              QCW_SUPPORTED = 1'b1,
    parameter bit              GATE_PRESENT  = 1'b1
)
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire safety_pins_t  safety_pins,
    input  wire monitor_pins_t monitor_pins,
    input  wire ctrl_status_t  ctrl_status,
    output logic               abnormal_program_end_out,
    output logic               program_sync_out,
    output logic               warning_out,
    output logic [GATE_W-1:0]  gate_channel_status,
    output logic               cooler_warning_out,
    output logic               cooler_alarm_out,
    output logic               pulsed_mode_out,
    output logic [ADDR_W-1:0]  unit_address_out,
    output logic               main_power_on_out,
    output logic               optical_power_en_out,
    output logic               emission_inhibit_out,
    output logic               error_latched_out,
    output logic               reset_loop_open_out,
    output logic               loop_fault_out
);

    // ==========================================================
    // Parameter checks
    // ==========================================================
    generate
        if (DEB_CYC < 1 || ARST_CYC < 1 || DEB_CYC > (2 ** CNT_W) || ARST_CYC > (2 ** CNT_W))
        begin : g_bad_param
            $error("laser_interlock_status_outputs: counts do not fit CNT_W");
        end
    endgenerate

    // ==========================================================
    // Pin conditioning
    // ==========================================================
    logic [NUM_DEB-1:0]        raw_pins;
    logic [NUM_DEB-1:0]        deb_pins;
    monitor_pins_t             mon_meta_ff;
    monitor_pins_t             mon_sync_ff;

    assign raw_pins[DEB_CH_A] = safety_pins.ch_a_closed;
    assign raw_pins[DEB_CH_B] = safety_pins.ch_b_closed;
    assign raw_pins[DEB_STOP] = safety_pins.stop_pressed;
    assign raw_pins[DEB_STRT] = safety_pins.start_pressed;
    assign raw_pins[DEB_ARST] = safety_pins.alarm_reset;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DEB; gi++)
        begin : g_deb
            // The alarm reset input must stay high for its minimum time
            pin_debounce
            #(
                .STABLE_CYC (gi == DEB_ARST ? ARST_CYC : DEB_CYC),
                .CNT_W      (CNT_W),
                .INIT_LVL   (1'b0)
            )
            u_deb
            (
                .clk        (clk),
                .rst_b      (rst_b),
                .pin        (raw_pins[gi]),
                .level      (deb_pins[gi])
            );  // [R17] [R16]
        end
    endgenerate

    // Monitor and cooler pins only need a plain two-flop synchroniser
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mon_meta_ff <= '0;
            mon_sync_ff <= '0;
        end
        else
        begin
            mon_meta_ff <= monitor_pins;
            mon_sync_ff <= mon_meta_ff;
        end
    end

    logic                      ch_a;
    logic                      ch_b;
    logic                      both_closed;
    logic                      both_open;

    assign ch_a        = deb_pins[DEB_CH_A];
    assign ch_b        = deb_pins[DEB_CH_B];
    assign both_closed = ch_a & ch_b;
    assign both_open   = ~ch_a & ~ch_b;

    // ==========================================================
    // Edge detection on debounced pins
    // ==========================================================
    logic                      start_d_ff;
    logic                      arst_d_ff;
    logic                      start_rise;
    logic                      arst_rise;

    assign start_rise = deb_pins[DEB_STRT] & ~start_d_ff;
    assign arst_rise  = deb_pins[DEB_ARST] & ~arst_d_ff;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            start_d_ff <= 1'b1;
            arst_d_ff  <= 1'b1;
        end
        else
        begin
            start_d_ff <= deb_pins[DEB_STRT];
            arst_d_ff  <= deb_pins[DEB_ARST];
        end
    end

    // ==========================================================
    // Two-channel loop state
    // ==========================================================
    loop_state_t               loop_ff;
    loop_state_t               nxt_loop;

    always_comb
    begin
        nxt_loop = loop_ff;
        case (loop_ff)
            LOOP_OPEN:
            begin
                if (both_closed)
                begin
                    nxt_loop = LOOP_ARMED;
                end
            end
            LOOP_ARMED:
            begin
                if (both_open)
                begin
                    nxt_loop = LOOP_OPEN;
                end
                else if (!both_closed)
                begin
                    nxt_loop = LOOP_ONE_OPEN;  // [R10]
                end
            end
            LOOP_ONE_OPEN:
            begin
                // Reclosing the same channel is not enough
                if (both_open)
                begin
                    nxt_loop = LOOP_OPEN;  // [R10]
                end
            end
            default:
            begin
                nxt_loop = LOOP_OPEN;
            end
        endcase
    end

    // ==========================================================
    // Error latch and main power
    // ==========================================================
    logic                      error_ff;
    logic                      nxt_error;
    logic                      power_ff;
    logic                      nxt_power;
    logic                      fault;
    logic                      loop_ok;

    assign fault   = mon_sync_ff.ch_short | mon_sync_ff.start_short;
    assign loop_ok = (loop_ff == LOOP_ARMED) & both_closed;  // [R9]

    always_comb
    begin
        nxt_error = error_ff;
        // Reset is refused while a short is still present; set wins
        if (arst_rise && !fault && !mon_sync_ff.error_det)
        begin
            nxt_error = 1'b0;  // [R15] [R16]
        end
        if (mon_sync_ff.error_det || fault)
        begin
            nxt_error = 1'b1;  // [R14]
        end
    end

    always_comb
    begin
        nxt_power = power_ff;
        if (start_rise && loop_ok && !deb_pins[DEB_STOP] && !error_ff && !mon_sync_ff.error_det && !fault)
        begin
            nxt_power = 1'b1;  // [R12]
        end
        if (!loop_ok || deb_pins[DEB_STOP] || error_ff || mon_sync_ff.error_det || fault)
        begin
            nxt_power = 1'b0;  // [R11] [R13] [R14]
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            loop_ff  <= LOOP_OPEN;
            error_ff <= 1'b0;
            power_ff <= 1'b0;
        end
        else
        begin
            loop_ff  <= nxt_loop;
            error_ff <= nxt_error;
            power_ff <= nxt_power;
        end
    end

    // ==========================================================
    // Status outputs
    // ==========================================================
    logic                      abend_ff;
    logic                      nxt_abend;
    logic                      sync_ff;
    logic                      warn_ff;
    logic [GATE_W-1:0]         gate_ff;
    logic [GATE_W-1:0]         nxt_gate;
    logic                      cwarn_ff;
    logic                      calarm_ff;
    logic                      qcw_ff;
    logic [ADDR_W-1:0]         addr_ff;
    logic                      inhibit_ff;

    always_comb
    begin
        nxt_abend = abend_ff;
        if (deb_pins[DEB_ARST])
        begin
            nxt_abend = 1'b0;  // [R1]
        end
        if (ctrl_status.prog_abort)
        begin
            nxt_abend = 1'b1;  // [R1]
        end
    end

    always_comb
    begin
        nxt_gate = GATE_ALL_CLOSED;
        if (GATE_PRESENT)
        begin
            case (ctrl_status.gate_sel)
                2'h1:    nxt_gate = GATE_CH1;  // [R4]
                2'h2:    nxt_gate = GATE_CH2;  // [R4]
                2'h3:    nxt_gate = GATE_CH3;  // [R4]
                default: nxt_gate = GATE_ALL_CLOSED;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            abend_ff   <= 1'b0;
            sync_ff    <= 1'b0;
            warn_ff    <= 1'b0;
            gate_ff    <= GATE_ALL_CLOSED;
            cwarn_ff   <= 1'b0;
            calarm_ff  <= 1'b0;
            qcw_ff     <= 1'b0;
            addr_ff    <= ADDR_RESET;
            inhibit_ff <= 1'b1;
        end
        else
        begin
            abend_ff   <= nxt_abend;
            sync_ff    <= ctrl_status.prog_mode & ctrl_status.prog_sync;  // [R2]
            warn_ff    <= ctrl_status.warning;  // [R3]
            gate_ff    <= nxt_gate;
            cwarn_ff   <= mon_sync_ff.cooler_warn;  // [R5]
            calarm_ff  <= mon_sync_ff.cooler_alarm;  // [R6]
            qcw_ff     <= QCW_SUPPORTED & ctrl_status.qcw_active;  // [R7]
            addr_ff    <= ctrl_status.unit_addr;  // [R8]
            inhibit_ff <= mon_sync_ff.cooler_alarm | ~nxt_power;  // [R6] [R11]
        end
    end

    assign abnormal_program_end_out = abend_ff;
    assign program_sync_out         = sync_ff;
    assign warning_out              = warn_ff;
    assign gate_channel_status      = gate_ff;
    assign cooler_warning_out       = cwarn_ff;
    assign cooler_alarm_out         = calarm_ff;
    assign pulsed_mode_out          = qcw_ff;
    assign unit_address_out         = addr_ff;
    assign main_power_on_out        = power_ff;
    assign optical_power_en_out     = power_ff;
    assign emission_inhibit_out     = inhibit_ff;
    assign error_latched_out        = error_ff;
    assign reset_loop_open_out      = error_ff;
    assign loop_fault_out           = loop_ff == LOOP_ONE_OPEN;

endmodule : laser_interlock_status_outputs
`default_nettype wire

/* hw/ilk_pkg.sv */
// Package for the laser interlock and status output block.
// Assumes one 125 MHz system clock and a synchronous active-low reset.
package ilk_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_PERIOD_PS    = 8000;
    localparam int DEBOUNCE_US      = 1000;
    localparam int ALARM_RST_MIN_US = 1000;
    localparam int DEBOUNCE_CYC     = (DEBOUNCE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ALARM_RST_CYC    = (ALARM_RST_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ==========================================================
    // Field widths and codes
    // ==========================================================
    localparam int GATE_W = 4;
    localparam int ADDR_W = 4;
    localparam int SEL_W  = 2;

    localparam logic [GATE_W-1:0] GATE_ALL_CLOSED = 4'h0;
    localparam logic [GATE_W-1:0] GATE_CH1        = 4'h1;
    localparam logic [GATE_W-1:0] GATE_CH2        = 4'h2;
    localparam logic [GATE_W-1:0] GATE_CH3        = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_RESET      = 4'h0;

    // Debounced pin slots
    localparam int NUM_DEB  = 5;
    localparam int DEB_CH_A = 0;
    localparam int DEB_CH_B = 1;
    localparam int DEB_STOP = 2;
    localparam int DEB_STRT = 3;
    localparam int DEB_ARST = 4;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        LOOP_OPEN     = 2'b00,
        LOOP_ARMED    = 2'b01,
        LOOP_ONE_OPEN = 2'b10
    } loop_state_t;

    // Safety connector pins, all high when closed or pressed
    typedef struct packed {
        logic ch_a_closed;
        logic ch_b_closed;
        logic stop_pressed;
        logic start_pressed;
        logic alarm_reset;
    } safety_pins_t;

    // Fault monitors and cooler pins, asynchronous to clk
    typedef struct packed {
        logic ch_short;
        logic start_short;
        logic error_det;
        logic cooler_warn;
        logic cooler_alarm;
    } monitor_pins_t;

    // Status from the laser control logic, same clock
    typedef struct packed {
        logic               prog_abort;
        logic               prog_mode;
        logic               prog_sync;
        logic               warning;
        logic               qcw_active;
        logic [SEL_W-1:0]   gate_sel;
        logic [ADDR_W-1:0]  unit_addr;
    } ctrl_status_t;

endpackage : ilk_pkg

/* hw/pin_debounce.sv */
// Two-flop synchroniser followed by a stability filter for one pin.
// Assumes the pin is asynchronous to clk; output changes only after
// the synchronised level has held for STABLE_CYC cycles.
`timescale 1ns/10ps
`default_nettype none
module pin_debounce
#(
    parameter int          STABLE_CYC = 125000,
    parameter int          CNT_W      = 17,
    parameter logic        INIT_LVL   = 1'b0
)
(
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire logic      pin,
    output logic           level
);

    logic                  meta_ff;
    logic                  sync_ff;
    logic [CNT_W-1:0]      cnt_ff;
    logic [CNT_W-1:0]      nxt_cnt;
    logic                  level_ff;
    logic                  nxt_level;

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STABLE_CYC - 1);

    generate
        if (STABLE_CYC < 1 || STABLE_CYC > (2 ** CNT_W))
        begin : g_bad_param
            $error("pin_debounce: STABLE_CYC does not fit CNT_W");
        end
    endgenerate

    always_comb
    begin
        nxt_cnt   = '0;
        nxt_level = level_ff;
        if (sync_ff != level_ff)
        begin
            if (cnt_ff == CNT_LAST)
            begin
                nxt_level = sync_ff;
            end
            else
            begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta_ff  <= INIT_LVL;
            sync_ff  <= INIT_LVL;
            cnt_ff   <= '0;
            level_ff <= INIT_LVL;
        end
        else
        begin
            meta_ff  <= pin;
            sync_ff  <= meta_ff;
            cnt_ff   <= nxt_cnt;
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;

endmodule : pin_debounce
`default_nettype wire

/* testbench/interlock_monitor.sv */
// Concurrent checks on the interlock and status output block.
// Assumes the ports of laser_interlock_status_outputs, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module interlock_monitor
    import ilk_pkg::*;
(
    input wire logic          clk,
    input wire logic          rst_b,
    input wire safety_pins_t  safety_pins,
    input wire monitor_pins_t monitor_pins,
    input wire ctrl_status_t  ctrl_status,
    input wire logic          abnormal_program_end_out,
    input wire logic          program_sync_out,
    input wire logic          warning_out,
    input wire logic [3:0]    gate_channel_status,
    input wire logic          cooler_warning_out,
    input wire logic          cooler_alarm_out,
    input wire logic          pulsed_mode_out,
    input wire logic [3:0]    unit_address_out,
    input wire logic          main_power_on_out,
    input wire logic          optical_power_en_out,
    input wire logic          emission_inhibit_out,
    input wire logic          error_latched_out,
    input wire logic          reset_loop_open_out,
    input wire logic          loop_fault_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Status outputs
    // ==========================================================
    AST_ABEND_SET: assert property (ctrl_status.prog_abort |=> abnormal_program_end_out)
        else $error("abnormal end not set after abort");
    AST_SYNC_OUT: assert property ($past(rst_b) |-> program_sync_out == $past(ctrl_status.prog_mode && ctrl_status.prog_sync))
        else $error("sync output wrong");
    AST_WARN_OUT: assert property ($past(rst_b) |-> warning_out == $past(ctrl_status.warning))
        else $error("warning output wrong");
    AST_GATE_CODE: assert property ($past(rst_b) |-> gate_channel_status == {2'h0, $past(ctrl_status.gate_sel)})
        else $error("gate code wrong");
    AST_COOL_WARN: assert property (monitor_pins.cooler_warn [*4] |=> cooler_warning_out)
        else $error("cooler warning missing");
    AST_COOL_INHIBIT: assert property (cooler_alarm_out && $past(cooler_alarm_out) |-> emission_inhibit_out)
        else $error("emission not inhibited in cooler alarm");
    AST_PULSED: assert property ($past(rst_b) |-> pulsed_mode_out == $past(ctrl_status.qcw_active))
        else $error("pulsed mode output wrong");
    AST_ADDR: assert property ($past(rst_b) |-> unit_address_out == $past(ctrl_status.unit_addr))
        else $error("unit address wrong");

    // ==========================================================
    // Power and error latch
    // ==========================================================
    AST_POWER_START: assert property ($rose(main_power_on_out) |-> safety_pins.ch_a_closed && safety_pins.ch_b_closed)
        else $error("power started with a channel open");
    AST_OPTICAL: assert property (optical_power_en_out == main_power_on_out)
        else $error("optical power differs from main power");
    AST_OPT_OFF_LOOP: assert property (loop_fault_out |-> !optical_power_en_out && !main_power_on_out)
        else $error("power on with one channel open");
    AST_ERR_OFF: assert property (error_latched_out |-> !main_power_on_out && reset_loop_open_out)
        else $error("power on with error latched");
    AST_ERR_HOLD: assert property ((!safety_pins.alarm_reset) [*8] ##0 error_latched_out |=> error_latched_out)
        else $error("error latch dropped without reset");
    AST_SHORT_LATCH: assert property (monitor_pins.ch_short [*4] |=> error_latched_out)
        else $error("channel short not latched");
endmodule : interlock_monitor

bind laser_interlock_status_outputs interlock_monitor u_monitor
(
    .clk                      (clk),
    .rst_b                    (rst_b),
    .safety_pins              (safety_pins),
    .monitor_pins             (monitor_pins),
    .ctrl_status              (ctrl_status),
    .abnormal_program_end_out (abnormal_program_end_out),
    .program_sync_out         (program_sync_out),
    .warning_out              (warning_out),
    .gate_channel_status      (gate_channel_status),
    .cooler_warning_out       (cooler_warning_out),
    .cooler_alarm_out         (cooler_alarm_out),
    .pulsed_mode_out          (pulsed_mode_out),
    .unit_address_out         (unit_address_out),
    .main_power_on_out        (main_power_on_out),
    .optical_power_en_out     (optical_power_en_out),
    .emission_inhibit_out     (emission_inhibit_out),
    .error_latched_out        (error_latched_out),
    .reset_loop_open_out      (reset_loop_open_out),
    .loop_fault_out           (loop_fault_out)
);
`default_nettype wire

/* testbench/machine_ctrl_model.sv */
// Model of the machine controller on the safety connector.
// Assumes the bench sets the wanted pin levels just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module machine_ctrl_model
    import ilk_pkg::*;
#(
    parameter int             HOLD_CYC = 28
)
(
    input  wire logic         clk,
    input  wire logic         ch_a,
    input  wire logic         ch_b,
    input  wire logic         stop_p,
    input  wire logic         start_p,
    input  wire logic         arst_go,
    output var safety_pins_t  safety_pins
);
    int cnt = 0;

    initial safety_pins = '0;

    // Both channels are opened and closed as commanded
    // Alarm reset is held high well beyond the minimum time
    always @(posedge clk)
    begin
        if (arst_go)
            cnt = HOLD_CYC;
        else if (cnt > 0)
            cnt = cnt - 1;
        safety_pins <= #1 {ch_a, ch_b, stop_p, start_p, (cnt > 0)};
    end
endmodule : machine_ctrl_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the interlock and status output block.
// Assumes short debounce and alarm reset counts set by parameter.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ilk_pkg::*;
    localparam int DEB  = 8;
    localparam int ARST = 16;
    localparam int D    = DEB + 6;
    localparam int HOLD = ARST + DEB + 4;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ch_a = 1'b0, ch_b = 1'b0, stop_p = 1'b0, start_p = 1'b0, arst_go = 1'b0;
    safety_pins_t  pins;
    monitor_pins_t mon = '0;
    ctrl_status_t  cs = '0;
    logic abend, sync_o, warn, cwarn, calarm, pulsed, pwr, opt, inhib, err, rloop, lfault;
    logic [3:0] gate, addr;
    int n_mismatch = 0;
    int n_checks = 0;

    always #4 clk = ~clk;

    machine_ctrl_model #(.HOLD_CYC(HOLD)) u_ctrl (.clk(clk), .ch_a(ch_a), .ch_b(ch_b), .stop_p(stop_p),
        .start_p(start_p), .arst_go(arst_go), .safety_pins(pins));

    laser_interlock_status_outputs #(.DEB_CYC(DEB), .ARST_CYC(ARST), .CNT_W(17)) dut (.clk(clk), .rst_b(rst_b),
        .safety_pins(pins), .monitor_pins(mon), .ctrl_status(cs), .abnormal_program_end_out(abend),
        .program_sync_out(sync_o), .warning_out(warn), .gate_channel_status(gate), .cooler_warning_out(cwarn),
        .cooler_alarm_out(calarm), .pulsed_mode_out(pulsed), .unit_address_out(addr), .main_power_on_out(pwr),
        .optical_power_en_out(opt), .emission_inhibit_out(inhib), .error_latched_out(err),
        .reset_loop_open_out(rloop), .loop_fault_out(lfault));

    // ==========================================================
    // Helpers
    // ==========================================================
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task chk(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task press;
        start_p = 1'b1;
        cyc(D);
        start_p = 1'b0;
        cyc(D);
    endtask : press

    task alarm_clear;
        arst_go = 1'b1;
        cyc(1);
        arst_go = 1'b0;
        cyc(HOLD + D);
    endtask : alarm_clear

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // ==========================================================
    // Scenarios
    // ==========================================================
    task t_status;
        logic [3:0] av [3];
        av = '{4'h0, 4'h1, 4'hF};
        chk({3'h0, pwr}, 4'h0);
        chk({3'h0, inhib}, 4'h1);
        for (int g = 0; g < 4; g++)
        begin
            cs.gate_sel = 2'(g);
            cyc(2);
            chk(gate, 4'(g));
        end
        for (int i = 0; i < 3; i++)
        begin
            cs.unit_addr = av[i];
            cyc(2);
            chk(addr, av[i]);
        end
        cs.prog_sync = 1'b1;
        cyc(2);
        chk({3'h0, sync_o}, 4'h0);
        cs.prog_mode = 1'b1;
        cs.warning = 1'b1;
        cs.qcw_active = 1'b1;
        cyc(2);
        chk({2'h0, sync_o, warn}, 4'h3);
        chk({3'h0, pulsed}, 4'h1);
        cs = '0;
        cs.prog_abort = 1'b1;
        cyc(1);
        cs.prog_abort = 1'b0;
        cyc(3);
        chk({2'h0, pulsed, abend}, 4'h1);
        alarm_clear();
        chk({3'h0, abend}, 4'h0);
    endtask : t_status

    task t_power;
        ch_a = 1'b1;
        cyc(D);
        press();
        chk({3'h0, pwr}, 4'h0);
        ch_b = 1'b1;
        cyc(D);
        press();
        chk({1'h0, pwr, opt, inhib}, 4'h6);
        mon.cooler_warn = 1'b1;
        cyc(4);
        chk({3'h0, cwarn}, 4'h1);
        mon.cooler_warn = 1'b0;
        mon.cooler_alarm = 1'b1;
        cyc(4);
        chk({1'h0, cwarn, calarm, inhib}, 4'h3);
        mon.cooler_alarm = 1'b0;
        cyc(4);
        chk({3'h0, calarm}, 4'h0);
    endtask : t_power

    task t_one_open;
        ch_a = 1'b0;
        cyc(D);
        chk({1'h0, pwr, opt, lfault}, 4'h1);
        ch_a = 1'b1;
        cyc(D);
        press();
        chk({3'h0, pwr}, 4'h0);
        ch_a = 1'b0;
        ch_b = 1'b0;
        cyc(D);
        ch_a = 1'b1;
        ch_b = 1'b1;
        cyc(D);
        press();
        chk({2'h0, pwr, lfault}, 4'h2);
        stop_p = 1'b1;
        cyc(D);
        press();
        chk({3'h0, pwr}, 4'h0);
        stop_p = 1'b0;
        cyc(D);
        press();
        chk({3'h0, pwr}, 4'h1);
    endtask : t_one_open

    task t_error;
        mon.error_det = 1'b1;
        cyc(2);
        mon.error_det = 1'b0;
        cyc(3);
        chk({1'h0, err, rloop, pwr}, 4'h6);
        press();
        chk({3'h0, pwr}, 4'h0);
        alarm_clear();
        chk({3'h0, err}, 4'h0);
        mon.ch_short = 1'b1;
        cyc(5);
        alarm_clear();
        chk({3'h0, err}, 4'h1);
        mon.ch_short = 1'b0;
        mon.start_short = 1'b1;
        cyc(5);
        alarm_clear();
        chk({3'h0, err}, 4'h1);
        mon.start_short = 1'b0;
        cyc(4);
        alarm_clear();
        chk({3'h0, err}, 4'h0);
        press();
        chk({3'h0, pwr}, 4'h1);
        ch_a = 1'b0;
        cyc(3);
        ch_a = 1'b1;
        cyc(D);
        chk({3'h0, pwr}, 4'h1);
    endtask : t_error

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial
    begin
        cyc(16);
        rst_b = 1'b1;
        cyc(1);
        t_status();
        t_power();
        t_one_open();
        t_error();
        summarize();
    end

    initial
    begin
        #(8 * 20000);
        n_mismatch++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
